// ==== core/core_event_pkg.sv ====
/*
 * Shared constants and types for the core event prioritizer:
 * event level numbers, vector widths, latency figures and the
 * packed carrier for the fixed core event requests.
 * Assumes a single core clock domain and no software-visible registers.
 */
package core_event_pkg;

    // ==========================================================
    // Level numbering (lower number wins)
    // ==========================================================
    localparam int unsigned LEVEL_COUNT      = 16;
    localparam int unsigned LEVEL_W          = 4;
    localparam int unsigned LEVEL_SCAN_W     = 5;
    localparam logic [3:0]  LVL_EMULATION    = 4'h0;
    localparam logic [3:0]  LVL_RESET        = 4'h1;
    localparam logic [3:0]  LVL_NMI          = 4'h2;
    localparam logic [3:0]  LVL_EXCEPTION    = 4'h3;
    localparam logic [3:0]  LVL_RESERVED     = 4'h4;
    localparam logic [3:0]  LVL_HW_ERROR     = 4'h5;
    localparam logic [3:0]  LVL_CORE_TIMER   = 4'h6;
    localparam logic [3:0]  LVL_GENERAL_7    = 4'h7;
    localparam logic [3:0]  LVL_GENERAL_8    = 4'h8;
    localparam logic [3:0]  LVL_GENERAL_14   = 4'hE;
    localparam logic [3:0]  LVL_GENERAL_15   = 4'hF;
    localparam int unsigned GENERAL_COUNT    = 9;
    // Peripheral error requests land on this level by default
    localparam logic [3:0]  LVL_PERIPH_ERROR = LVL_GENERAL_7;
    // Scan result meaning "no level set"
    localparam logic [4:0]  LVL_NONE         = 5'h10;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS    = 25;
    // Least core cycles from a general request to its pending bit
    localparam int unsigned GEN_LATENCY_CYC  = 3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef logic [LEVEL_W-1:0]       level_t;
    typedef logic [LEVEL_SCAN_W-1:0]  level_scan_t;
    typedef logic [LEVEL_COUNT-1:0]   level_vec_t;
    typedef logic [GENERAL_COUNT-1:0] general_vec_t;

    // Fixed core event requests, one level each
    typedef struct packed {
        logic emulation_event;
        logic reset_event;
        logic nmi_event;
        logic exception_event;
        logic hardware_error_event;
        logic core_timer_event;
    } core_events_t;

    localparam level_vec_t RESET_VEC = 16'h0000;

endpackage

// ==== core/core_event_prioritizer.sv ====
/*
 * Core event prioritizer: latches core and general interrupt requests,
 * picks the highest-priority one that may preempt current service, and
 * flags nested service levels in the pending-level output.
 * Assumes requests come from logic on CLK_SYS and that the sequencer
 * pulses SERVICE_RETURN once per finished handler.
 */
`timescale 1ns/10ps
`default_nettype none

module core_event_prioritizer (
    input  wire logic                         CLK_SYS,
    input  wire logic                         RESET_N,
    input  wire core_event_pkg::core_events_t CORE_EVENTS,
    input  wire core_event_pkg::general_vec_t GENERAL_REQ,
    input  wire logic                         PERIPH_ERROR_REQ,
    input  wire logic                         SERVICE_RETURN,
    output logic [15:0]                       PENDING_LEVEL_OUTPUT,
    output logic [3:0]                        ACTIVE_LEVEL,
    output logic                              ACTIVE_VALID,
    output logic                              EVENT_TAKEN,
    output logic [3:0]                        TAKEN_LEVEL
);

    // ==========================================================
    // Helpers
    // ==========================================================
    // Lowest set bit index, LVL_NONE when empty
    function automatic core_event_pkg::level_scan_t lowest_set(
        input core_event_pkg::level_vec_t vec
    );
        core_event_pkg::level_scan_t idx;
        idx = core_event_pkg::LVL_NONE;
        for (int i = core_event_pkg::LEVEL_COUNT - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = core_event_pkg::level_scan_t'(i);
            end
        end
        return idx;
    endfunction

    // ==========================================================
    // Request assembly
    // ==========================================================
    core_event_pkg::level_vec_t  raw_req;
    core_event_pkg::level_vec_t  stage_r;
    core_event_pkg::level_vec_t  latch_r;
    core_event_pkg::level_vec_t  latch_nxt;
    core_event_pkg::level_vec_t  pending_r;
    core_event_pkg::level_vec_t  pending_nxt;
    core_event_pkg::level_vec_t  eligible;
    core_event_pkg::level_vec_t  candidates;
    core_event_pkg::level_vec_t  take_vec;
    core_event_pkg::level_vec_t  ret_vec;
    core_event_pkg::level_scan_t pend_low;
    core_event_pkg::level_scan_t win_scan;
    core_event_pkg::level_scan_t next_low;
    logic                        take;
    core_event_pkg::general_vec_t general_in;

    assign general_in = GENERAL_REQ
        | (core_event_pkg::general_vec_t'(PERIPH_ERROR_REQ)
           << (core_event_pkg::LVL_PERIPH_ERROR - core_event_pkg::LVL_GENERAL_7));

    assign raw_req[core_event_pkg::LVL_EMULATION]  = CORE_EVENTS.emulation_event;
    assign raw_req[core_event_pkg::LVL_RESET]      = CORE_EVENTS.reset_event;
    assign raw_req[core_event_pkg::LVL_NMI]        = CORE_EVENTS.nmi_event;
    // exception level, reserved level tied off
    assign raw_req[core_event_pkg::LVL_EXCEPTION]  = CORE_EVENTS.exception_event;
    assign raw_req[core_event_pkg::LVL_RESERVED]   = 1'b0;
    assign raw_req[core_event_pkg::LVL_HW_ERROR]   = CORE_EVENTS.hardware_error_event;
    assign raw_req[core_event_pkg::LVL_CORE_TIMER] = CORE_EVENTS.core_timer_event;
    // general levels 7 to 15, level 15 last
    assign raw_req[core_event_pkg::LVL_GENERAL_15:core_event_pkg::LVL_GENERAL_7] = general_in;

    // ==========================================================
    // Selection
    // ==========================================================
    // Only levels above current service may preempt it
    assign pend_low = lowest_set(pending_r);
    always_comb begin
        for (int i = 0; i < core_event_pkg::LEVEL_COUNT; i++) begin
            eligible[i] = (core_event_pkg::level_scan_t'(i) < pend_low);
        end
    end

    assign candidates = latch_r & eligible;
    assign win_scan   = lowest_set(candidates);
    assign take       = (win_scan != core_event_pkg::LVL_NONE);
    assign take_vec   = take ? (core_event_pkg::level_vec_t'(1) << win_scan[3:0])
                             : core_event_pkg::RESET_VEC;

    // Return retires only the innermost service level
    assign ret_vec = (SERVICE_RETURN && pend_low != core_event_pkg::LVL_NONE)
                   ? (core_event_pkg::level_vec_t'(1) << pend_low[3:0])
                   : core_event_pkg::RESET_VEC;

    // New request wins over the clear of its own latch
    assign latch_nxt   = (latch_r & ~take_vec) | stage_r;
    // winner's bit joins the nested service set
    assign pending_nxt = (pending_r & ~ret_vec) | take_vec;
    assign next_low    = lowest_set(pending_nxt);

    // ==========================================================
    // State
    // ==========================================================
    // request stage, latch, then pending: three edges
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            stage_r   <= core_event_pkg::RESET_VEC;
            latch_r   <= core_event_pkg::RESET_VEC;
            pending_r <= core_event_pkg::RESET_VEC;
        end else begin
            stage_r   <= raw_req;
            latch_r   <= latch_nxt;
            pending_r <= pending_nxt;
        end
    end

    // Status outputs registered for clean timing into the sequencer
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ACTIVE_LEVEL <= core_event_pkg::LVL_EMULATION;
            ACTIVE_VALID <= 1'b0;
            EVENT_TAKEN  <= 1'b0;
            TAKEN_LEVEL  <= core_event_pkg::LVL_EMULATION;
        end else begin
            ACTIVE_LEVEL <= next_low[3:0];
            ACTIVE_VALID <= (next_low != core_event_pkg::LVL_NONE);
            EVENT_TAKEN  <= take;
            TAKEN_LEVEL  <= win_scan[3:0];
        end
    end

    assign PENDING_LEVEL_OUTPUT = pending_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    // Highest level wins whenever it is latched and free
    emulation_first_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        latch_r[core_event_pkg::LVL_EMULATION] && !pending_r[core_event_pkg::LVL_EMULATION]
        |=> EVENT_TAKEN && TAKEN_LEVEL == core_event_pkg::LVL_EMULATION
            && PENDING_LEVEL_OUTPUT[core_event_pkg::LVL_EMULATION])
        else $error("emulation event not taken first");

    reset_over_nmi_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        latch_r[core_event_pkg::LVL_RESET] && latch_r[core_event_pkg::LVL_NMI]
        && !latch_r[core_event_pkg::LVL_EMULATION] && pend_low > 5'h01
        |=> TAKEN_LEVEL == core_event_pkg::LVL_RESET && EVENT_TAKEN)
        else $error("reset did not beat nonmaskable interrupt");

    reserved_level_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !PENDING_LEVEL_OUTPUT[core_event_pkg::LVL_RESERVED]
        && !(EVENT_TAKEN && TAKEN_LEVEL == core_event_pkg::LVL_RESERVED))
        else $error("reserved level raised");

    hw_error_rank_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        latch_r[core_event_pkg::LVL_HW_ERROR] && latch_r[core_event_pkg::LVL_CORE_TIMER]
        && latch_r[4:0] == 5'h00 && pending_r[5:0] == 6'h00
        |=> TAKEN_LEVEL == core_event_pkg::LVL_HW_ERROR)
        else $error("hardware error lost to lower level");

    timer_over_general_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        latch_r[core_event_pkg::LVL_CORE_TIMER] && latch_r[core_event_pkg::LVL_GENERAL_7]
        && latch_r[5:0] == 6'h00 && pending_r[6:0] == 7'h00
        |=> TAKEN_LEVEL == core_event_pkg::LVL_CORE_TIMER)
        else $error("core timer lost to general level");

    general_order_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        EVENT_TAKEN |-> (($past(candidates) >> TAKEN_LEVEL) & 16'h0001) == 16'h0001
            && ($past(candidates) & ((16'h0001 << TAKEN_LEVEL) - 16'h0001)) == 16'h0000)
        else $error("taken level was not the lowest eligible");

    sequence general_quiet_s;
        (!PENDING_LEVEL_OUTPUT[core_event_pkg::LVL_GENERAL_8]) [*2];
    endsequence

    general_latency_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        GENERAL_REQ[1] && !stage_r[core_event_pkg::LVL_GENERAL_8]
        && !latch_r[core_event_pkg::LVL_GENERAL_8]
        && !pending_r[core_event_pkg::LVL_GENERAL_8]
        |=> general_quiet_s)
        else $error("general level pending too early");

    lowest_level_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        EVENT_TAKEN && TAKEN_LEVEL == core_event_pkg::LVL_GENERAL_15
        |-> $past(latch_r[14:0]) == 15'h0000)
        else $error("level 15 served ahead of higher level");

    periph_route_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        PERIPH_ERROR_REQ |-> ##2 latch_r[core_event_pkg::LVL_GENERAL_7])
        else $error("peripheral error not on level 7");

    preempt_rank_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        EVENT_TAKEN |-> {1'b0, TAKEN_LEVEL} < $past(pend_low)
            && PENDING_LEVEL_OUTPUT[TAKEN_LEVEL] && ACTIVE_LEVEL == TAKEN_LEVEL)
        else $error("preemption by lower priority level");

endmodule

`default_nettype wire

// ==== tb/handler_model.sv ====
/*
 * Behavioural model of the core sequencer's handler side: on a start
 * request it spends a chosen number of cycles in the handler, then
 * pulses the one-cycle service return.
 * Assumes one core clock; it drives just after the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none

module handler_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [3:0] hold,
    output logic            svc_return
);
    logic [3:0] cnt_r;
    logic       run_r;
    logic       svc_r;

    assign svc_return = svc_r;

    // ==========================================================
    // Handler timing: zero hold answers promptly, larger is slow
    // ==========================================================
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
            cnt_r <= 4'h0;
            svc_r <= 1'b0;
        end else begin
            svc_r <= 1'b0;
            if (start && !run_r) begin
                run_r <= 1'b1;
                cnt_r <= hold;
            end else if (run_r) begin
                // One pulse only, so one level retires per request
                if (cnt_r == 4'h0) begin
                    svc_r <= 1'b1;
                    run_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/core_event_prioritizer_bench.sv ====
/*
 * Self-checking bench for the core event prioritizer.
 * Assumes the package, the design and the handler model compile first.
 */
`timescale 1ns/10ps
`default_nettype none

module core_event_prioritizer_bench;
    // ==========================================================
    // Signals and clock
    // ==========================================================
    logic                         clk_sys = 1'b0;
    logic                         reset_n = 1'b0;
    core_event_pkg::core_events_t core_ev = '0;
    core_event_pkg::general_vec_t gen_req = '0;
    logic                         periph_err = 1'b0;
    logic                         ret_start = 1'b0;
    logic [3:0]                   ret_hold = 4'h0;
    logic                         svc_return;
    logic [15:0]                  pend;
    logic [3:0]                   act_lvl;
    logic                         act_valid;
    logic                         taken;
    logic [3:0]                   taken_lvl;
    int                           err_total = 0;
    int                           n_compared = 0;
    int                           cyc = 0;

    // Half period of the 40 MHz core clock
    always #12.5 clk_sys = ~clk_sys;

    core_event_prioritizer core_event_prioritizer_inst (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .CORE_EVENTS(core_ev),
        .GENERAL_REQ(gen_req), .PERIPH_ERROR_REQ(periph_err),
        .SERVICE_RETURN(svc_return), .PENDING_LEVEL_OUTPUT(pend),
        .ACTIVE_LEVEL(act_lvl), .ACTIVE_VALID(act_valid),
        .EVENT_TAKEN(taken), .TAKEN_LEVEL(taken_lvl));

    handler_model handler_model_inst (
        .clk(clk_sys), .rst_n(reset_n), .start(ret_start),
        .hold(ret_hold), .svc_return(svc_return));

    // Hang guard; the whole run needs under two hundred cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Level to input bit; the struct lists level 0 as its top bit
    task automatic req(input int lv, input logic v);
        if (lv < 7) core_ev[lv < 4 ? 5 - lv : 6 - lv] <= v;
        else gen_req[lv - 7] <= v;
    endtask

    // One-cycle request, then watch it reach the pending output
    task automatic raise(input int lv, input logic [15:0] prior);
        req(lv, 1'b1);
        @(negedge clk_sys);
        req(lv, 1'b0);
        @(negedge clk_sys);
        check(pend, prior);
        @(negedge clk_sys);
        check(pend, prior | (16'h0001 << lv));
        check({15'h0, taken}, 16'h0001);
        check({12'h0, taken_lvl}, 16'(lv));
    endtask

    // Handler model finishes the innermost level after a delay
    task automatic retire(input logic [3:0] hold, input logic [15:0] left);
        ret_hold <= hold;
        ret_start <= 1'b1;
        @(negedge clk_sys);
        ret_start <= 1'b0;
        // Model sees start one edge late, the clear lands one edge after its pulse
        repeat (hold + 2) @(negedge clk_sys);
        check(pend, left);
        check({15'h0, act_valid}, {15'h0, left != 16'h0});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        check(pend, 16'h0000);
        check({11'h0, act_valid, act_lvl}, 16'h0000);
        $display("test reset done");
    endtask

    // Every level but the reserved level 4 alone, prompt and slow handlers mixed
    task automatic t_levels;
        for (int lv = 0; lv < 16; lv++) begin
            if (lv != 4) begin
                raise(lv, 16'h0000);
                check({12'h0, act_lvl}, 16'(lv));
                retire(4'(lv % 3), 16'h0000);
            end
        end
        $display("test levels done");
    endtask

    task automatic t_periph;
        periph_err <= 1'b1;
        @(negedge clk_sys);
        periph_err <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check(pend, 16'h0080);
        retire(4'h1, 16'h0000);
        $display("test periph done");
    endtask

    // Two at once, then a preempting hardware error
    task automatic t_nested;
        req(14, 1'b1);
        req(8, 1'b1);
        @(negedge clk_sys);
        req(14, 1'b0);
        req(8, 1'b0);
        repeat (3) @(negedge clk_sys);
        check(pend, 16'h0100);
        raise(5, 16'h0100);
        check({12'h0, act_lvl}, 16'h0005);
        retire(4'h0, 16'h0100);
        retire(4'h2, 16'h0000);
        for (int i = 0; i < 8 && taken !== 1'b1; i++) @(negedge clk_sys);
        check({15'h0, taken}, 16'h0001);
        check({12'h0, taken_lvl}, 16'h000E);
        check(pend, 16'h4000);
        retire(4'h1, 16'h0000);
        $display("test nested done");
    endtask

    // Two neighbours at once: the higher wins, the other follows its return
    task automatic t_pairs;
        int hi;
        for (int p = 0; p < 3; p++) begin
            hi = (p == 0) ? 1 : p + 4;
            req(hi, 1'b1);
            req(hi + 1, 1'b1);
            @(negedge clk_sys);
            req(hi, 1'b0);
            req(hi + 1, 1'b0);
            repeat (2) @(negedge clk_sys);
            check(pend, 16'h0001 << hi);
            check({12'h0, taken_lvl}, 16'(hi));
            retire(4'h0, 16'h0000);
            @(negedge clk_sys);
            check(pend, 16'h0001 << (hi + 1));
            retire(4'h0, 16'h0000);
        end
        $display("test pairs done");
    endtask

    // Reset in mid-run drops every level in service
    task automatic t_midreset;
        raise(9, 16'h0000);
        reset_n <= 1'b0;
        @(negedge clk_sys);
        check(pend, 16'h0000);
        check({11'h0, act_valid, act_lvl}, 16'h0000);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        check({15'h0, taken}, 16'h0000);
        check(pend, 16'h0000);
        $display("test midreset done");
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_levels();
        t_periph();
        t_nested();
        t_pairs();
        t_midreset();
        report_and_stop();
    end
endmodule

`default_nettype wire
